// *** analog_input_live_zero_monitor.sv ***
// analog input routing, scaling, live-zero watch and hand/auto priority
`timescale 1ns/1ps
`include "alz_defines.svh"
module analog_input_live_zero_monitor #(
  parameter int unsigned TICK_CYCLES = `ONE_SEC_NS / `CLK_NS
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic hand_start_pin,
  input wire logic auto_start_pin,
  input wire logic hand_term_en,
  input wire logic auto_term_en,
  input wire logic key_hand,
  input wire logic key_auto,
  input wire logic key_off,
  input wire logic term_start,
  input wire logic serial_start,
  input wire logic [7:0] volt_a_sample,
  input wire logic [7:0] volt_b_sample,
  input wire logic [7:0] curr_sample,
  input wire logic [15:0] therm_a_ohm,
  input wire logic [15:0] therm_b_ohm,
  input wire logic cfg_load,
  input wire logic [1:0] voltage_input_a_function,
  input wire logic [1:0] voltage_input_b_function,
  input wire logic [1:0] current_input_function,
  input wire logic [7:0] voltage_input_a_min_point,
  input wire logic [7:0] voltage_input_a_max_point,
  input wire logic [7:0] voltage_input_b_min_point,
  input wire logic [7:0] voltage_input_b_max_point,
  input wire logic [7:0] current_input_min_point,
  input wire logic [7:0] current_input_max_point,
  input wire logic [6:0] signal_loss_timeout,
  input wire logic [2:0] signal_loss_action,
  input wire logic [1:0] thermal_prot_mode,
  input wire logic bus_timeout,
  input wire logic [2:0] bus_action,
  input wire logic trip_clear,
  output logic off_mode,
  output logic hand_mode,
  output logic auto_mode,
  output logic start_accept,
  output logic motor_run,
  output logic [11:0] ref_sum,
  output logic [11:0] fb_sum,
  output logic overtemp,
  output logic [2:0] signal_loss,
  output logic [2:0] timeout_action,
  output logic drive_stop,
  output logic trip
);

  // ==========================================================
  // helper functions
  // linear map of a sample between two points onto 0..1000
  function automatic logic [9:0] scale_value(input logic [7:0] x, input logic [7:0] lo,
                                             input logic [7:0] hi);
    logic [17:0] num;
    logic [17:0] quo;
    num = '0;
    quo = '0;
    if (hi <= lo || x <= lo)
      scale_value = '0;
    else if (x >= hi)
      scale_value = `SCALE_FULL;
    else
    begin
      num = 18'(x - lo) * 18'(`SCALE_FULL);
      quo = num / {10'h000, 8'(hi - lo)};
      scale_value = quo[9:0];
    end
  endfunction

  // clip a scaling point to the top of its range
  function automatic logic [7:0] clip_point(input logic [7:0] x, input logic [7:0] top);
    clip_point = (x > top) ? top : x;
  endfunction

  // unknown action codes behave as no action
  function automatic logic [2:0] clip_action(input logic [2:0] a);
    clip_action = (a > `ACT_STOP_TRIP) ? `ACT_NONE : a;
  endfunction

  // ==========================================================
  // state
  logic [1:0] hand_sync_reg, auto_sync_reg;
  alz_pkg::mode_e mode_reg, mode_next, req_mode;
  logic [1:0] func_reg [3], eff_func [3];
  logic [7:0] min_reg [3], max_reg [3], sample [3];
  logic [6:0] timeout_reg, loss_cnt_reg [3];
  logic [26:0] tick_cnt_reg;
  logic [9:0] scaled [3];
  logic [2:0] action_reg, timeout_action_reg, loss_act_clip, act_sel;
  logic [2:0] signal_loss_reg, mon_en, below;
  logic overtemp_reg, drive_stop_reg, trip_reg, start_accept_reg, motor_run_reg;
  logic tick_reg, overtemp_next, stop_act;
  logic [11:0] ref_sum_reg, fb_sum_reg, ref_sum_next, fb_sum_next;

  // ==========================================================
  // terminal synchronisers, only the second stage is read
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hand_sync_reg <= 2'h0;
      auto_sync_reg <= 2'h0;
    end
    else
    begin
      hand_sync_reg <= {hand_sync_reg[0], hand_start_pin};
      auto_sync_reg <= {auto_sync_reg[0], auto_start_pin};
    end
  end

  // ==========================================================
  // hand/auto/off mode selection
  always_comb
  begin
    req_mode = mode_reg;
    if (hand_term_en || auto_term_en)
    begin
      if (auto_term_en && auto_sync_reg[1])
        req_mode = alz_pkg::MODE_AUTO;
      else if (hand_term_en && hand_sync_reg[1])
        req_mode = alz_pkg::MODE_HAND;
      else
        req_mode = alz_pkg::MODE_OFF;
    end
    else if (key_auto)
      req_mode = alz_pkg::MODE_AUTO;
    else if (key_hand)
      req_mode = alz_pkg::MODE_HAND;
    else if (key_off)
      req_mode = alz_pkg::MODE_OFF;
    case (mode_reg)
      alz_pkg::MODE_OFF, alz_pkg::MODE_HAND, alz_pkg::MODE_AUTO: mode_next = req_mode;
      default: mode_next = alz_pkg::MODE_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      mode_reg <= alz_pkg::MODE_OFF;
    else
      mode_reg <= mode_next;
  end

  // ==========================================================
  // configuration capture with documented defaults
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      func_reg[`IDX_VA] <= `DEF_FUNC_VA;
      func_reg[`IDX_VB] <= `DEF_FUNC_VB;
      func_reg[`IDX_CUR] <= `DEF_FUNC_CUR;
      min_reg[`IDX_VA] <= `DEF_V_MIN;
      min_reg[`IDX_VB] <= `DEF_V_MIN;
      max_reg[`IDX_VA] <= `DEF_V_MAX;
      max_reg[`IDX_VB] <= `DEF_V_MAX;
      min_reg[`IDX_CUR] <= `DEF_I_MIN;
      max_reg[`IDX_CUR] <= `DEF_I_MAX;
      timeout_reg <= `DEF_TIMEOUT;
      action_reg <= `ACT_NONE;
    end
    else if (cfg_load)
    begin
      func_reg[`IDX_VA] <= voltage_input_a_function;
      func_reg[`IDX_VB] <= voltage_input_b_function;
      func_reg[`IDX_CUR] <= current_input_function;
      min_reg[`IDX_VA] <= clip_point(voltage_input_a_min_point, `V_TOP);
      max_reg[`IDX_VA] <= clip_point(voltage_input_a_max_point, `V_TOP);
      min_reg[`IDX_VB] <= clip_point(voltage_input_b_min_point, `V_TOP);
      max_reg[`IDX_VB] <= clip_point(voltage_input_b_max_point, `V_TOP);
      min_reg[`IDX_CUR] <= clip_point(current_input_min_point, `I_TOP);
      max_reg[`IDX_CUR] <= clip_point(current_input_max_point, `I_TOP);
      timeout_reg <= (signal_loss_timeout < `TIMEOUT_MIN) ? `TIMEOUT_MIN :
        ((signal_loss_timeout > `TIMEOUT_MAX) ? `TIMEOUT_MAX : signal_loss_timeout);
      action_reg <= clip_action(signal_loss_action);
    end
  end

  // ==========================================================
  // routing, scaling, sums and live-zero conditions
  assign sample[`IDX_VA] = volt_a_sample;
  assign sample[`IDX_VB] = volt_b_sample;
  assign sample[`IDX_CUR] = curr_sample;

  always_comb
  begin
    ref_sum_next = '0;
    fb_sum_next = '0;
    for (int i = 0; i < `NUM_INPUTS; i++)
    begin
      eff_func[i] = func_reg[i];
      if (i == `IDX_CUR && func_reg[i] == `FUNC_THERM)
        eff_func[i] = `FUNC_NONE;
      scaled[i] = scale_value(sample[i], min_reg[i], max_reg[i]);
      if (eff_func[i] == `FUNC_REF)
        ref_sum_next = ref_sum_next + 12'(scaled[i]);
      if (eff_func[i] == `FUNC_FB)
        fb_sum_next = fb_sum_next + 12'(scaled[i]);
      mon_en[i] = (eff_func[i] == `FUNC_REF || eff_func[i] == `FUNC_FB) &&
                  (min_reg[i] > ((i == `IDX_CUR) ? `LZ_EN_I : `LZ_EN_V));
      below[i] = ({1'b0, sample[i]} << 1) < {1'b0, min_reg[i]};
    end
  end

  // thermistor cut-out, only with thermal protection armed
  assign overtemp_next = (thermal_prot_mode == `PROT_WARN || thermal_prot_mode == `PROT_TRIP) &&
    ((eff_func[`IDX_VA] == `FUNC_THERM && therm_a_ohm >= `THERM_CUTOUT_OHM) ||
     (eff_func[`IDX_VB] == `FUNC_THERM && therm_b_ohm >= `THERM_CUTOUT_OHM));

  // analog loss action overrules the bus timeout action
  assign loss_act_clip = action_reg;
  assign act_sel = (|signal_loss_reg) ? loss_act_clip :
                   (bus_timeout ? clip_action(bus_action) : `ACT_NONE);
  assign stop_act = (act_sel == `ACT_STOP) || (act_sel == `ACT_STOP_TRIP);

  // ==========================================================
  // one second tick and per-input loss timers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= (tick_cnt_reg == 27'(TICK_CYCLES - 1));
      tick_cnt_reg <= (tick_cnt_reg == 27'(TICK_CYCLES - 1)) ? '0 : tick_cnt_reg + 27'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < `NUM_INPUTS; i++)
        loss_cnt_reg[i] <= '0;
      signal_loss_reg <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < `NUM_INPUTS; i++)
      begin
        if (!mon_en[i] || !below[i])
          loss_cnt_reg[i] <= '0;
        else if (tick_reg && loss_cnt_reg[i] <= timeout_reg)
          loss_cnt_reg[i] <= loss_cnt_reg[i] + 7'h01;
        signal_loss_reg[i] <= mon_en[i] && below[i] && (loss_cnt_reg[i] > timeout_reg);
      end
    end
  end

  // ==========================================================
  // outputs: action, stop, trip, run and sums
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timeout_action_reg <= `ACT_NONE;
      overtemp_reg <= 1'b0;
      drive_stop_reg <= 1'b0;
      trip_reg <= 1'b0;
      start_accept_reg <= 1'b0;
      motor_run_reg <= 1'b0;
      ref_sum_reg <= '0;
      fb_sum_reg <= '0;
    end
    else
    begin
      timeout_action_reg <= act_sel;
      overtemp_reg <= overtemp_next;
      // set wins over the clear
      trip_reg <= (act_sel == `ACT_STOP_TRIP) || (trip_reg && !trip_clear);
      drive_stop_reg <= overtemp_next || stop_act || trip_reg;
      start_accept_reg <= (mode_reg == alz_pkg::MODE_AUTO) && (term_start || serial_start);
      motor_run_reg <= !(overtemp_next || stop_act || trip_reg) &&
        ((mode_reg == alz_pkg::MODE_HAND) ||
         ((mode_reg == alz_pkg::MODE_AUTO) && (term_start || serial_start)));
      ref_sum_reg <= ref_sum_next;
      fb_sum_reg <= fb_sum_next;
    end
  end

  assign off_mode = mode_reg[0];
  assign hand_mode = mode_reg[1];
  assign auto_mode = mode_reg[2];
  assign start_accept = start_accept_reg;
  assign motor_run = motor_run_reg;
  assign ref_sum = ref_sum_reg;
  assign fb_sum = fb_sum_reg;
  assign overtemp = overtemp_reg;
  assign signal_loss = signal_loss_reg;
  assign timeout_action = timeout_action_reg;
  assign drive_stop = drive_stop_reg;
  assign trip = trip_reg;

  // ==========================================================
  // checks
  AST_AUTO_WINS: assert property (@(posedge clk_sys) disable iff (!arst_n)
    auto_term_en && auto_sync_reg[1] && hand_sync_reg[1] |=> auto_mode && !hand_mode)
    else $error("auto start did not win over hand start");
  AST_OFF_IDLE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (hand_term_en || auto_term_en) && !auto_sync_reg[1] && !hand_sync_reg[1]
    |=> off_mode ##1 !motor_run)
    else $error("no terminal start did not give off mode");
  AST_KEYS_OVERRULED: assert property (@(posedge clk_sys) disable iff (!arst_n)
    hand_term_en && hand_sync_reg[1] && !(auto_term_en && auto_sync_reg[1]) && key_auto
    |=> hand_mode)
    else $error("panel key overruled a terminal request");
  AST_AUTO_ACCEPT: assert property (@(posedge clk_sys) disable iff (!arst_n)
    auto_mode && serial_start |=> start_accept)
    else $error("auto mode did not accept a serial start");
  AST_NOOP_NO_REF: assert property (@(posedge clk_sys) disable iff (!arst_n)
    eff_func[0] != `FUNC_REF && eff_func[1] != `FUNC_REF && eff_func[2] != `FUNC_REF
    |=> ref_sum == 12'h000)
    else $error("reference sum not zero with no reference input");
  AST_FULL_SCALE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    eff_func[0] == `FUNC_REF && eff_func[1] != `FUNC_REF && eff_func[2] != `FUNC_REF &&
    max_reg[0] > min_reg[0] && volt_a_sample >= max_reg[0] |=> ref_sum == 12'(`SCALE_FULL))
    else $error("input at max point did not give full scale");
  AST_THERM_STOP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    eff_func[0] == `FUNC_THERM && thermal_prot_mode == `PROT_TRIP &&
    therm_a_ohm >= `THERM_CUTOUT_OHM |=> overtemp && drive_stop && !motor_run)
    else $error("thermistor cut-out did not stop the drive");
  AST_LOSS_GATED: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !mon_en[2] |=> !signal_loss[2])
    else $error("loss flagged on an unwatched current input");
  AST_LOSS_TIME: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(signal_loss[0]) |-> $past(loss_cnt_reg[0]) > $past(timeout_reg))
    else $error("loss flagged before the timeout ran out");
  AST_LOSS_BEATS_BUS: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (|signal_loss_reg) && bus_timeout |=> timeout_action == $past(loss_act_clip))
    else $error("bus action taken over analog loss action");
  AST_STOP_TRIP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    act_sel == `ACT_STOP_TRIP |=> trip && drive_stop ##1 drive_stop)
    else $error("stop and trip did not latch a trip");

endmodule

// *** alz_defines.svh ***
// constants for the analog input, live-zero and hand/auto block
// Summary of operation
// - enabled hand/auto terminal inputs overrule the hand and auto panel keys.
// - auto-start at logic 1 gives auto mode, accepting terminal or serial starts.
// - auto-start and hand-start together: auto wins, hand is ignored.
// - neither auto-start nor hand-start active: motor stops, off/stop mode.
// - function codes 0 none, 1 reference, 2 feedback; 3 thermistor voltage only.
// - an input set to no operation affects nothing.
// - several reference inputs are added into one analog reference.
// - thermistor resistance reaching 3 kohm flags overtemperature and stops the drive.
// - voltage minimum point spans 0-10 V, default 0 V.
// - voltage maximum point defaults to 10 V.
// - current minimum point spans 0-20 mA, default 4 mA.
// - current maximum point defaults to 20 mA.
// - below half minimum point longer than timeout (1-99 s, default 10) acts.
// - loss watch only when minimum exceeds 1 V or 2 mA.
// - timeout action codes 0 none .. 5 stop and trip.
// - analog loss and bus timeout together: analog loss action wins.
`ifndef ALZ_DEFINES_SVH
`define ALZ_DEFINES_SVH
`define NUM_INPUTS 32'h3
`define IDX_VA 0
`define IDX_VB 1
`define IDX_CUR 2
`define FUNC_NONE 2'h0
`define FUNC_REF 2'h1
`define FUNC_FB 2'h2
`define FUNC_THERM 2'h3
`define ACT_NONE 3'h0
`define ACT_FREEZE 3'h1
`define ACT_STOP 3'h2
`define ACT_JOG 3'h3
`define ACT_MAXF 3'h4
`define ACT_STOP_TRIP 3'h5
`define DEF_FUNC_VA 2'h1
`define DEF_FUNC_VB 2'h0
`define DEF_FUNC_CUR 2'h1
`define V_TOP 8'h64
`define DEF_V_MIN 8'h00
`define DEF_V_MAX 8'h64
`define I_TOP 8'hC8
`define DEF_I_MIN 8'h28
`define DEF_I_MAX 8'hC8
`define LZ_EN_V 8'h0A
`define LZ_EN_I 8'h14
`define TIMEOUT_MIN 7'h01
`define TIMEOUT_MAX 7'h63
`define DEF_TIMEOUT 7'h0A
`define THERM_CUTOUT_OHM 16'h0BB8
`define PROT_WARN 2'h1
`define PROT_TRIP 2'h2
`define SCALE_FULL 10'h3E8
`define ONE_SEC_NS 32'h3B9ACA00
`define CLK_NS 32'h8
`endif

// *** alz_pkg.sv ***
// types shared by the analog input, live-zero and hand/auto block
package alz_pkg;
  typedef enum logic [2:0] {
    MODE_OFF = 3'h1,
    MODE_HAND = 3'h2,
    MODE_AUTO = 3'h4
  } mode_e;
endpackage

// *** alz_source_model.sv ***
// behavioural model of the external transmitters and motor thermistors
`timescale 1ns/1ps
module alz_source_model (
  input wire logic clk_sys,
  input wire logic [2:0] wire_cut,
  input wire logic [7:0] lvl_a,
  input wire logic [7:0] lvl_b,
  input wire logic [7:0] lvl_c,
  input wire logic [15:0] ohm_a,
  input wire logic [15:0] ohm_b,
  output logic [7:0] volt_a_sample,
  output logic [7:0] volt_b_sample,
  output logic [7:0] curr_sample,
  output logic [15:0] therm_a_ohm,
  output logic [15:0] therm_b_ohm
);
  // converter readings; a cut line reads zero as its input is pulled down
  always_ff @(posedge clk_sys)
  begin
    volt_a_sample <= wire_cut[0] ? 8'h00 : lvl_a;
    volt_b_sample <= wire_cut[1] ? 8'h00 : lvl_b;
    curr_sample <= wire_cut[2] ? 8'h00 : lvl_c;
  end
  // an open thermistor loop reads as a very high resistance
  always_ff @(posedge clk_sys)
  begin
    therm_a_ohm <= wire_cut[0] ? 16'hFFFF : ohm_a;
    therm_b_ohm <= wire_cut[1] ? 16'hFFFF : ohm_b;
  end
endmodule

// *** analog_input_live_zero_monitor_tb.sv ***
// self-checking bench for the analog input, live-zero and hand/auto block
`timescale 1ns/1ps
module analog_input_live_zero_monitor_tb;
  typedef struct {string name; logic [11:0] exp;} note_s;
  logic clk_sys = 1'b0, arst_n = 1'b0, chk = 1'b0, cfg_load = 1'b0;
  logic hand_start_pin = 1'b0, auto_start_pin = 1'b0, hand_term_en = 1'b0, auto_term_en = 1'b0;
  logic key_hand = 1'b0, key_auto = 1'b0, key_off = 1'b0, term_start = 1'b0, serial_start = 1'b0;
  logic bus_timeout = 1'b0, trip_clear = 1'b0;
  logic [1:0] voltage_input_a_function = 2'h1, voltage_input_b_function = 2'h0;
  logic [1:0] current_input_function = 2'h1, thermal_prot_mode = 2'h0;
  logic [7:0] voltage_input_a_min_point = 8'h00, voltage_input_a_max_point = 8'h50;
  logic [7:0] voltage_input_b_min_point = 8'h00, voltage_input_b_max_point = 8'h50;
  logic [7:0] current_input_min_point = 8'h28, current_input_max_point = 8'hC8;
  logic [6:0] signal_loss_timeout = 7'h01;
  logic [2:0] signal_loss_action = 3'h0, bus_action = 3'h4, wire_cut = 3'h0;
  logic [7:0] lvl_a = 8'h32, lvl_b = 8'h4D, lvl_c = 8'h78;
  logic [15:0] ohm_a = 16'h03E8, ohm_b = 16'h03E8;
  logic [7:0] volt_a_sample, volt_b_sample, curr_sample;
  logic [15:0] therm_a_ohm, therm_b_ohm;
  logic off_mode, hand_mode, auto_mode, start_accept, motor_run, overtemp, drive_stop, trip;
  logic [11:0] ref_sum, fb_sum;
  logic [2:0] signal_loss, timeout_action;
  note_s notes[$];
  note_s cur_note;
  int bad_count = 0, num_checks = 0, cycles = 0;

  // ==========================================================
  // clock, design and far-side model
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  analog_input_live_zero_monitor #(.TICK_CYCLES(20)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .hand_start_pin(hand_start_pin), .auto_start_pin(auto_start_pin),
    .hand_term_en(hand_term_en), .auto_term_en(auto_term_en), .key_hand(key_hand),
    .key_auto(key_auto), .key_off(key_off), .term_start(term_start),
    .serial_start(serial_start), .volt_a_sample(volt_a_sample), .volt_b_sample(volt_b_sample),
    .curr_sample(curr_sample), .therm_a_ohm(therm_a_ohm), .therm_b_ohm(therm_b_ohm),
    .cfg_load(cfg_load), .voltage_input_a_function(voltage_input_a_function),
    .voltage_input_b_function(voltage_input_b_function),
    .current_input_function(current_input_function),
    .voltage_input_a_min_point(voltage_input_a_min_point),
    .voltage_input_a_max_point(voltage_input_a_max_point),
    .voltage_input_b_min_point(voltage_input_b_min_point),
    .voltage_input_b_max_point(voltage_input_b_max_point),
    .current_input_min_point(current_input_min_point),
    .current_input_max_point(current_input_max_point),
    .signal_loss_timeout(signal_loss_timeout), .signal_loss_action(signal_loss_action),
    .thermal_prot_mode(thermal_prot_mode), .bus_timeout(bus_timeout), .bus_action(bus_action),
    .trip_clear(trip_clear), .off_mode(off_mode), .hand_mode(hand_mode), .auto_mode(auto_mode),
    .start_accept(start_accept), .motor_run(motor_run), .ref_sum(ref_sum), .fb_sum(fb_sum),
    .overtemp(overtemp), .signal_loss(signal_loss), .timeout_action(timeout_action),
    .drive_stop(drive_stop), .trip(trip));
  alz_source_model src_u (.clk_sys(clk_sys), .wire_cut(wire_cut), .lvl_a(lvl_a),
    .lvl_b(lvl_b), .lvl_c(lvl_c), .ohm_a(ohm_a), .ohm_b(ohm_b),
    .volt_a_sample(volt_a_sample), .volt_b_sample(volt_b_sample), .curr_sample(curr_sample),
    .therm_a_ohm(therm_a_ohm), .therm_b_ohm(therm_b_ohm));

  // ==========================================================
  // notes, comparison and verdict
  function automatic int scale(input int x, input int mn, input int mx);
    if (x <= mn || mx <= mn)
      return 0;
    if (x >= mx)
      return 1000;
    return (x - mn) * 1000 / (mx - mn);
  endfunction
  function automatic logic [11:0] got_of(input string nm);
    case (nm)
      "mode": return {9'h000, auto_mode, hand_mode, off_mode};
      "start": return {11'h000, start_accept};
      "ref": return ref_sum;
      "fb": return fb_sum;
      "sig": return {9'h000, signal_loss};
      "act": return {9'h000, timeout_action};
      "stop": return {11'h000, drive_stop};
      "trip": return {11'h000, trip};
      "run": return {11'h000, motor_run};
      default: return {11'h000, overtemp};
    endcase
  endfunction
  task automatic note(input string nm, input int e);
    notes.push_back('{nm, 12'(e)});
  endtask
  task automatic check_now();
    @(posedge clk_sys);
    #1 chk = 1'b1;
    @(posedge clk_sys);
    #1 chk = 1'b0;
  endtask
  task automatic cmp_val(input string nm, input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // takes every pending note off the queue on a check edge
  always @(posedge clk_sys)
  begin
    if (chk === 1'b1)
    begin
      while (notes.size() > 0)
      begin
        cur_note = notes.pop_front();
        cmp_val(cur_note.name, cur_note.exp, got_of(cur_note.name));
      end
    end
  end
  // hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      bad_count++;
      complete_run();
    end
  end
  task automatic cfg(input logic [1:0] fa, input logic [1:0] fc, input logic [7:0] vmn,
                     input logic [7:0] cmn, input logic [2:0] act);
    @(posedge clk_sys);
    #1;
    voltage_input_a_function = fa;
    voltage_input_b_function = 2'h2;
    current_input_function = fc;
    voltage_input_a_min_point = vmn;
    voltage_input_b_min_point = vmn;
    current_input_min_point = cmn;
    signal_loss_action = act;
    cfg_load = 1'b1;
    @(posedge clk_sys);
    #1 cfg_load = 1'b0;
  endtask
  task automatic wait_loss();
    int n;
    n = 0;
    while (signal_loss[0] !== 1'b1 && n < 60)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(32'hCB605344));
    repeat (12) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    note("mode", 1);
    note("trip", 0);
    check_now();
    repeat (3) @(posedge clk_sys);
    note("ref", 1000);
    note("fb", 0);
    check_now();
    // random samples against the default scaling points
    for (int i = 0; i < 8; i++)
    begin
      lvl_a = 8'($urandom_range(100));
      lvl_c = 8'($urandom_range(200, 20));
      repeat (4) @(posedge clk_sys);
      note("ref", scale(lvl_a, 0, 100) + scale(lvl_c, 40, 200));
      check_now();
    end
    // terminal requests with hand and auto keys held that must be ignored
    {hand_term_en, auto_term_en, key_hand, key_auto, term_start} = 5'h1F;
    for (int i = 0; i < 4; i++)
    begin
      {auto_start_pin, hand_start_pin} = 2'(i);
      repeat (6) @(posedge clk_sys);
      note("mode", auto_start_pin ? 4 : (hand_start_pin ? 2 : 1));
      note("start", auto_start_pin);
      note("run", i != 0);
      check_now();
    end
    {hand_term_en, auto_term_en, term_start, serial_start} = 4'h1;
    for (int k = 0; k < 3; k++)
    begin
      {key_off, key_auto, key_hand} = 3'(1 << k);
      repeat (4) @(posedge clk_sys);
      note("mode", k == 0 ? 2 : (k == 1 ? 4 : 1));
      note("start", k == 1);
      note("run", k != 2);
      check_now();
    end
    // feedback on both voltage inputs, thermistor code on the current input
    lvl_b = 8'h50;
    lvl_a = 8'h32;
    cfg(2'h2, 2'h3, 8'h14, 8'h28, 3'h0);
    repeat (4) @(posedge clk_sys);
    note("fb", 1500);
    note("ref", 0);
    check_now();
    // every after-timeout action, with a bus timeout pending alongside for codes 1-5
    for (int a = 0; a < 6; a++)
    begin
      cfg(2'h2, 2'h3, 8'h14, 8'h28, 3'(a));
      lvl_a = 8'h09;
      bus_timeout = (a != 0);
      repeat (15) @(posedge clk_sys);
      note("sig", 0);
      check_now();
      wait_loss();
      repeat (3) @(posedge clk_sys);
      note("sig", 1);
      note("act", a);
      note("stop", a == 2 || a == 5);
      note("trip", a == 5);
      check_now();
      lvl_a = 8'h32;
      bus_timeout = 1'b0;
      repeat (6) @(posedge clk_sys);
    end
    note("trip", 1);
    check_now();
    trip_clear = 1'b1;
    @(posedge clk_sys);
    #1 trip_clear = 1'b0;
    repeat (3) @(posedge clk_sys);
    note("trip", 0);
    note("stop", 0);
    check_now();
    // lost lines: voltage minimum at 1 V is not watched, current above 2 mA is
    cfg(2'h1, 2'h1, 8'h0A, 8'h15, 3'h0);
    wire_cut = 3'h5;
    repeat (80) @(posedge clk_sys);
    note("sig", 4);
    check_now();
    wire_cut = 3'h0;
    // thermistor cut-out against each protection setting
    for (int p = 0; p < 3; p++)
    begin
      for (int h = 0; h < 2; h++)
      begin
        thermal_prot_mode = 2'(p);
        cfg(2'h3, 2'h3, 8'h14, 8'h28, 3'h0);
        ohm_a = 16'h0BB7 + 16'(h);
        repeat (5) @(posedge clk_sys);
        note("ot", p != 0 && h == 1);
        note("stop", p != 0 && h == 1);
        check_now();
      end
    end
    // reference on one voltage input driven past its maximum point
    cfg(2'h1, 2'h0, 8'h14, 8'h28, 3'h0);
    lvl_a = 8'h5A;
    repeat (4) @(posedge clk_sys);
    note("ref", 1000);
    note("fb", 1000);
    note("ot", 0);
    note("run", 0);
    check_now();
    complete_run();
  end
endmodule
